// ==== adhp_pkg.sv ====
package adhp_pkg;
  localparam int RESULT_W = 12;
  localparam int CFG_W = 8;
  // Configuration byte field positions.
  localparam int PWR_HI_BIT = 7;
  localparam int PWR_LO_BIT = 6;
  localparam int ACQ_MODE_BIT = 5;
  localparam logic [1:0] PWR_FULL_DOWN = 2'h0;
  localparam logic [1:0] PWR_STANDBY = 2'h1;
  localparam logic [1:0] PWR_RUN_INT_CLK = 2'h2;
  localparam logic [1:0] PWR_RUN_EXT_CLK = 2'h3;
  localparam logic [7:0] CFG_RESET = 8'h80;
  // Internal conversion clock divider, acquisition length and conversion length.
  localparam logic [3:0] INT_CLK_DIV = 4'h4;
  localparam logic [3:0] ACQ_TICKS = 4'h6;
  localparam logic [3:0] CONV_TICKS = 4'hd;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ACQ = 4'h2,
    ST_CONV = 4'h4,
    ST_DONE = 4'h8
  } adhp_state_t;
endpackage : adhp_pkg

// ==== adhp_sync.sv ====
module adhp_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Asynchronous level in, synchronised level out
  input wire logic async_in,
  output logic sync_out
);
  logic stage1;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stage1 <= 1'b1;
      sync_out <= 1'b1;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : adhp_sync

// ==== adhp_host_port.sv ====
// Behaviour
// - With chip select low, a falling read strobe starts driving the result onto the bus.
// - In internal acquisition mode a rising write strobe latches the byte and, when the byte selects a run mode, runs acquire then convert.
// - In external acquisition mode a second rising write strobe ends acquisition and starts conversion.
// - With chip select high the done output and all result lines are high impedance.
// - Only the low eight data lines accept the configuration byte; the upper lines only drive.
// - Done goes low when a conversion finishes and the result is ready.
// - Power bits decode 00 power-down, 01 standby, 10 run internal clock, 11 run external clock.
// - The acquisition bit selects internal acquisition at 0 and external at 1.
module adhp_host_port
  import adhp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Host strobes, asynchronous
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic conv_clk_pin,
  // Data bus, output enables low while driving
  input wire logic [adhp_pkg::CFG_W-1:0] cfg_in,
  output logic [adhp_pkg::RESULT_W-1:0] result_bus,
  output logic [adhp_pkg::RESULT_W-1:0] result_bus_oe_n,
  output logic done_n,
  output logic done_n_oe_n,
  // Converter core side
  input wire logic [adhp_pkg::RESULT_W-1:0] sample_value,
  output logic acquiring,
  output logic converting,
  output logic [adhp_pkg::CFG_W-1:0] config_byte,
  output logic power_down,
  output logic standby
);
  import adhp_pkg::*;

  logic cs_s, rd_s, wr_s, clk_s;
  logic rd_q, wr_q, clk_q;
  adhp_state_t state, next_state;
  logic [3:0] tick_cnt, next_tick_cnt;
  logic [3:0] div_cnt, next_div_cnt;
  logic [CFG_W-1:0] next_config_byte;
  logic [CFG_W-1:0] cfg_s, cfg_hold, next_cfg_hold;
  logic [RESULT_W-1:0] result_q, next_result_q;
  logic next_done_n, next_acquiring, next_converting, next_power_down, next_standby;
  logic next_drive, drive;
  logic rd_fall, wr_rise, tick, ext_clk, ext_acq, int_tick;

  adhp_sync u_cs (.clk(clk), .arst_n(arst_n), .async_in(cs_n), .sync_out(cs_s));
  adhp_sync u_rd (.clk(clk), .arst_n(arst_n), .async_in(rd_n), .sync_out(rd_s));
  adhp_sync u_wr (.clk(clk), .arst_n(arst_n), .async_in(wr_n), .sync_out(wr_s));
  adhp_sync u_ck (.clk(clk), .arst_n(arst_n), .async_in(conv_clk_pin), .sync_out(clk_s));

  // Data lines pass the same two flops as the strobes, so both arrive with equal delay.
  genvar gi;
  generate
    for (gi = 0; gi < CFG_W; gi++)
    begin : g_cfg_sync
      adhp_sync u_cfg (.clk(clk), .arst_n(arst_n), .async_in(cfg_in[gi]), .sync_out(cfg_s[gi]));
    end
  endgenerate

  assign rd_fall = !cs_s && rd_q && !rd_s;
  assign wr_rise = !cs_s && !wr_q && wr_s;
  assign ext_clk = config_byte[PWR_HI_BIT] && config_byte[PWR_LO_BIT];
  assign ext_acq = config_byte[ACQ_MODE_BIT];
  assign int_tick = (div_cnt == INT_CLK_DIV - 4'h1);
  // Conversion steps on a falling pin clock in external mode; the pin is ignored otherwise.
  assign tick = ext_clk ? (clk_q && !clk_s) : int_tick;

  always_comb
  begin
    next_state = state;
    next_tick_cnt = tick_cnt;
    next_config_byte = config_byte;
    next_result_q = result_q;
    next_done_n = done_n;
    next_cfg_hold = cfg_hold;
    // The host may drop its data right after the write rise, so capture it while write is low.
    if (!cs_s && !wr_s)
    begin
      next_cfg_hold = cfg_s;
    end
    next_div_cnt = int_tick ? 4'h0 : div_cnt + 4'h1;
    case (state)
      ST_IDLE, ST_DONE:
      begin
        if (wr_rise)
        begin
          // Only the low byte is sampled; upper lines never read the bus.
          next_config_byte = cfg_hold;
          next_tick_cnt = 4'h0;
          if (cfg_hold[PWR_HI_BIT])
          begin
            next_state = ST_ACQ;
            next_done_n = 1'b1;
          end
          else
          begin
            next_state = ST_IDLE;
          end
        end
      end
      ST_ACQ:
      begin
        // External acquisition waits for a second write edge; internal counts ticks.
        if ((ext_acq && wr_rise) || (!ext_acq && tick && tick_cnt == ACQ_TICKS - 4'h1))
        begin
          next_state = ST_CONV;
          next_tick_cnt = 4'h0;
        end
        else if (!ext_acq && tick)
        begin
          next_tick_cnt = tick_cnt + 4'h1;
        end
      end
      ST_CONV:
      begin
        if (tick && tick_cnt == CONV_TICKS - 4'h1)
        begin
          next_state = ST_DONE;
          next_result_q = sample_value;
          next_done_n = 1'b0;
        end
        else if (tick)
        begin
          next_tick_cnt = tick_cnt + 4'h1;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
    if (rd_fall && state == ST_DONE)
    begin
      next_done_n = 1'b1;
    end
    next_drive = !cs_s && !rd_s;
    next_acquiring = (next_state == ST_ACQ);
    next_converting = (next_state == ST_CONV);
    next_power_down = (next_config_byte[PWR_HI_BIT:PWR_LO_BIT] == PWR_FULL_DOWN);
    next_standby = (next_config_byte[PWR_HI_BIT:PWR_LO_BIT] == PWR_STANDBY);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= ST_IDLE;
      tick_cnt <= 4'h0;
      div_cnt <= 4'h0;
      config_byte <= CFG_RESET;
      cfg_hold <= CFG_RESET;
      result_q <= '0;
      done_n <= 1'b1;
      drive <= 1'b0;
      rd_q <= 1'b1;
      wr_q <= 1'b1;
      clk_q <= 1'b1;
      acquiring <= 1'b0;
      converting <= 1'b0;
      power_down <= 1'b0;
      standby <= 1'b0;
      result_bus <= '0;
      result_bus_oe_n <= '1;
      done_n_oe_n <= 1'b1;
    end
    else
    begin
      state <= next_state;
      tick_cnt <= next_tick_cnt;
      div_cnt <= next_div_cnt;
      config_byte <= next_config_byte;
      cfg_hold <= next_cfg_hold;
      result_q <= next_result_q;
      done_n <= next_done_n;
      drive <= next_drive;
      rd_q <= rd_s;
      wr_q <= wr_s;
      clk_q <= clk_s;
      acquiring <= next_acquiring;
      converting <= next_converting;
      power_down <= next_power_down;
      standby <= next_standby;
      result_bus <= next_result_q;
      result_bus_oe_n <= {RESULT_W{!next_drive}};
      done_n_oe_n <= cs_s;
    end
  end

  a_cs_high_float: assert property (@(posedge clk) disable iff (!arst_n)
    cs_s |=> result_bus_oe_n == '1 && done_n_oe_n)
    else $error("outputs driven while deselected");
  a_read_drives: assert property (@(posedge clk) disable iff (!arst_n)
    rd_fall |=> result_bus_oe_n == '0)
    else $error("read did not drive bus");
  a_write_starts: assert property (@(posedge clk) disable iff (!arst_n)
    (state == ST_IDLE && wr_rise && cfg_hold[PWR_HI_BIT]) |=> state == ST_ACQ)
    else $error("write did not start acquisition");
  a_int_acq_end: assert property (@(posedge clk) disable iff (!arst_n)
    (state == ST_ACQ && !ext_acq && tick && tick_cnt == ACQ_TICKS - 4'h1) |=> state == ST_CONV)
    else $error("internal acquisition not ended");
  a_ext_acq_end: assert property (@(posedge clk) disable iff (!arst_n)
    (state == ST_ACQ && ext_acq && wr_rise) |=> state == ST_CONV)
    else $error("external acquisition not ended");
  a_done_low: assert property (@(posedge clk) disable iff (!arst_n)
    (state == ST_CONV && next_state == ST_DONE) |=> !done_n && result_q == $past(sample_value))
    else $error("done not signalled");
  a_done_clear: assert property (@(posedge clk) disable iff (!arst_n)
    (state == ST_DONE && rd_fall && !wr_rise) |=> done_n)
    else $error("done not cleared by read");
  a_cfg_latch: assert property (@(posedge clk) disable iff (!arst_n)
    ((state == ST_IDLE || state == ST_DONE) && wr_rise) |=> config_byte == $past(cfg_hold))
    else $error("config not latched");
  a_power_decode: assert property (@(posedge clk) disable iff (!arst_n)
    ##1 power_down == (config_byte[PWR_HI_BIT:PWR_LO_BIT] == PWR_FULL_DOWN))
    else $error("power decode wrong");
  c_conv_done: cover property (@(posedge clk) state == ST_CONV ##1 state == ST_DONE);
  c_ext_acq: cover property (@(posedge clk) state == ST_ACQ && ext_acq && wr_rise);
  c_read: cover property (@(posedge clk) state == ST_DONE && rd_fall);
  c_int_acq: cover property (@(posedge clk) state == ST_ACQ && !ext_acq ##1 state == ST_CONV);
  c_power_down: cover property (@(posedge clk) power_down && !standby);
endmodule : adhp_host_port

// ==== adhp_host_model.sv ====
module adhp_host_model
  import adhp_pkg::*;
(
  // Clock
  input wire logic clk,
  // Host strobes and pins
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic conv_clk_pin,
  // Low data lines
  output logic [adhp_pkg::CFG_W-1:0] cfg_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import adhp_pkg::*;
  logic ext_clk_en;
  initial
  begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    conv_clk_pin = 1'b1;
    cfg_in = 8'h5a;
    ext_clk_en = 1'b0;
  end
  // The pin clock only runs in external clock mode and rests static otherwise.
  // Its edges fall between system clock edges so the synchroniser never races them.
  initial
  begin
    #5;
    forever #50 if (ext_clk_en) conv_clk_pin = ~conv_clk_pin;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : hold
  task automatic select(input logic sel);
    cs_n = ~sel;
    hold(4);
  endtask : select
  task automatic write_cfg(input logic [CFG_W-1:0] b);
    cfg_in = b;
    wr_n = 1'b0;
    hold(4);
    wr_n = 1'b1;
    ext_clk_en = b[PWR_HI_BIT] & b[PWR_LO_BIT];
    // Callers write again after done or to end external acquisition, so write stays high past the first conversion clock fall.
    hold(4);
    // Released lines show the inverse so a stale byte cannot look valid.
    cfg_in = ~b;
  endtask : write_cfg
  task automatic read_start();
    rd_n = 1'b0;
    hold(5);
  endtask : read_start
  task automatic read_end();
    rd_n = 1'b1;
    hold(4);
  endtask : read_end
endmodule : adhp_host_model

// ==== adc_parallel_host_port_tb.sv ====
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin fails++; \
  $display("mismatch %s exp %h got %h", nm, exp, got); end end
module adc_parallel_host_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import adhp_pkg::*;
  logic clk, arst_n, cs_n, rd_n, wr_n, conv_clk_pin, done_n, done_n_oe_n;
  logic acquiring, converting, power_down, standby;
  logic [CFG_W-1:0] cfg_in, config_byte;
  logic [RESULT_W-1:0] result_bus, result_bus_oe_n, sample_value;
  int fails = 0;
  int num_checks = 0;
  adhp_host_port u_dut (.clk(clk), .arst_n(arst_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .conv_clk_pin(conv_clk_pin), .cfg_in(cfg_in), .result_bus(result_bus),
    .result_bus_oe_n(result_bus_oe_n), .done_n(done_n), .done_n_oe_n(done_n_oe_n),
    .sample_value(sample_value), .acquiring(acquiring), .converting(converting),
    .config_byte(config_byte), .power_down(power_down), .standby(standby));
  adhp_host_model u_host (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .conv_clk_pin(conv_clk_pin), .cfg_in(cfg_in));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic end_sim();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task automatic wait_for_done();
    int n;
    n = 0;
    while (done_n !== 1'b0 && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    #1;
    if (n == 2000)
    begin
      fails++;
      $display("mismatch %s exp %h got %h", "done_n_timeout", 1'b0, done_n);
      end_sim();
    end
  endtask : wait_for_done
  task automatic read_check(input logic [RESULT_W-1:0] exp);
    u_host.read_start();
    `CHK("result", exp, result_bus)
    `CHK("oe_n", {RESULT_W{1'b0}}, result_bus_oe_n)
    `CHK("done_n", 1'b1, done_n)
    u_host.read_end();
    `CHK("oe_n_rel", {RESULT_W{1'b1}}, result_bus_oe_n)
  endtask : read_check
  initial
  begin
    arst_n = 1'b0;
    sample_value = 12'ha5c;
    repeat (5) @(posedge clk);
    #1 arst_n = 1'b1;
    `CHK("oe_n", {RESULT_W{1'b1}}, result_bus_oe_n)
    `CHK("done_oe_n", 1'b1, done_n_oe_n)
    `CHK("config", CFG_RESET, config_byte)
    $display("test reset finished");
    u_host.select(1'b1);
    u_host.write_cfg(8'h80);
    `CHK("acquiring", 1'b1, acquiring)
    `CHK("config_int", 8'h80, config_byte)
    wait_for_done();
    `CHK("done_oe_n", 1'b0, done_n_oe_n)
    read_check(12'ha5c);
    $display("test internal acquisition finished");
    sample_value = 12'h3e1;
    u_host.write_cfg(8'he0);
    `CHK("acq_ext", 1'b1, acquiring)
    `CHK("config_ext", 8'he0, config_byte)
    u_host.hold(40);
    `CHK("acq_ext_held", 1'b1, acquiring)
    u_host.write_cfg(8'he0);
    `CHK("converting", 1'b1, converting)
    wait_for_done();
    read_check(12'h3e1);
    $display("test external acquisition finished");
    for (int i = 0; i < 2; i++)
    begin
      u_host.write_cfg({1'b0, i[0], 6'h00});
      `CHK("power_down", ~i[0], power_down)
      `CHK("standby", i[0], standby)
    end
    $display("test power modes finished");
    u_host.select(1'b0);
    `CHK("oe_n_off", {RESULT_W{1'b1}}, result_bus_oe_n)
    `CHK("done_off", 1'b1, done_n_oe_n)
    $display("test deselect finished");
    end_sim();
  end
endmodule : adc_parallel_host_port_tb
